// File: src/pmr_power_reset_ctrl.sv
// pmr_power_reset_ctrl: idle and power-down sequencer with internal reset
// sources, reset pin drive and an apb register file.
// assumes pins are synchronous to pclk; presetn is the power-up reset.
`timescale 1ns/1ps
module pmr_power_reset_ctrl
  import pmr_pkg::*;
#(
  parameter logic [7:0][18:0] SUT_CYCLES = PMR_SUT_CYC
)
(
  // clock and power-up reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core side events
  input  wire logic        ca_dog_match,
  input  wire logic        irq_pending,
  // reset pin, open drain or open source
  input  wire logic        rst_pin_in,
  input  wire logic        reset_sense_select,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  // external interrupt pins, active low
  input  wire logic [1:0]  ext_irq_n,
  // start-up fuses
  input  wire logic [1:0]  sut_fuse,
  input  wire logic        xtal_select,
  // power and reset outputs
  output pmr_pwr_t         pwr,
  output logic             sys_reset,
  output logic             dog_kick,
  output logic [1:0]       wake_irq
);
  // ==================================================================
  // state
  pmr_state_t state;
  pmr_state_t next_state;
  pmr_key_t   key_st;
  pmr_key_t   next_key;
  logic [5:0] pwr_ctl;
  logic [5:0] next_pwr_ctl;
  logic [3:0] cfg;
  logic [3:0] next_cfg;
  logic [3:0] irq_cfg;
  logic [1:0] irq_prev;
  logic [1:0] wake_src;
  logic       su_start;
  logic       su_busy;
  logic       su_done;
  logic       wake2;
  logic [5:0] int_left;
  logic       int_active;
  logic [5:0] pin_left;
  logic       pin_active;

  // ==================================================================
  // pin conditioning
  wire       rst_level  = reset_sense_select ? rst_pin_in : ~rst_pin_in;
  wire       rst_active = rst_level & ~rst_pin_oe;
  wire [1:0] irq_fall   = irq_prev & ~ext_irq_n;
  wire [1:0] irq_rise   = ~irq_prev & ext_irq_n;
  wire [1:0] irq_en     = irq_cfg[1:0];
  wire [1:0] irq_edge   = irq_cfg[3:2];
  wire [1:0] wake_ok    = irq_en & ~irq_edge & irq_fall;
  wire       in_down    = state == PMR_ST_DOWN || state == PMR_ST_WAKE_RST;

  // ==================================================================
  // apb decode
  wire setup   = psel & ~penable;
  wire acc     = psel & penable & pready;
  wire sel_pc  = paddr == {2'b00, PMR_IDX_PWRCTL, 2'b00};
  wire sel_key = paddr == {2'b00, PMR_IDX_KEY, 2'b00};
  wire sel_cfg = paddr == {2'b00, PMR_IDX_CFG, 2'b00};
  wire sel_irq = paddr == {2'b00, PMR_IDX_IRQ, 2'b00};
  wire sel_st  = paddr == {2'b00, PMR_IDX_STAT, 2'b00};
  wire mapped  = sel_pc | sel_key | sel_cfg | sel_irq | sel_st;
  wire wr_pc   = acc & pwrite & sel_pc;
  wire wr_key  = acc & pwrite & sel_key;
  wire wr_cfg  = acc & pwrite & sel_cfg;
  wire wr_irq  = acc & pwrite & sel_irq;
  wire [7:0] stat_word = {1'b0, sys_reset, su_busy, key_st, state};

  // read mux; key register reads as zero
  wire [31:0] next_rdata =
    sel_pc  ? {26'h000_0000, pwr_ctl} :
    sel_cfg ? {28'h000_0000, cfg} :
    sel_irq ? {28'h000_0000, irq_cfg} :
    sel_st  ? {24'h00_0000, stat_word} : 32'h0000_0000;

  // apb answers one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= setup ? next_rdata : prdata;
    end
  end

  // ==================================================================
  // key sequence decode
  wire [7:0] kb        = pwdata[7:0];
  wire key_open_soft   = wr_key && key_st == PMR_K_IDLE && kb == PMR_KEY_SOFT1;
  wire key_open_dog    = wr_key && key_st == PMR_K_IDLE && kb == PMR_KEY_DOG1;
  wire key_soft        = wr_key && key_st == PMR_K_SOFT && kb == PMR_KEY_SOFT2;
  wire key_kick        = wr_key && key_st == PMR_K_DOG && kb == PMR_KEY_DOG2;
  wire key_bad         = wr_key & ~key_open_soft & ~key_open_dog
                         & ~key_soft & ~key_kick;
  wire soft_any        = key_soft | key_bad;

  assign next_key = sys_reset ? PMR_K_IDLE :
                    key_open_soft ? PMR_K_SOFT :
                    key_open_dog ? PMR_K_DOG :
                    wr_key ? PMR_K_IDLE : key_st;

  // ==================================================================
  // merged internal reset: longest request wins
  wire       int_load = ca_dog_match | soft_any | wake2;
  wire [5:0] int_len  = soft_any ? PMR_SOFT_PULSE :
                        ca_dog_match ? PMR_CA_PULSE : PMR_WAKE_PULSE;

  pmr_pulse_stretch u_int_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (int_load),
    .len     (int_len),
    .left    (int_left),
    .active  (int_active)
  );

  // pin pulse: only software resets, and only when not blocked
  wire pin_load = soft_any & ~cfg[PMR_CF_ROB];

  pmr_pulse_stretch u_pin_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (pin_load),
    .len     (PMR_SOFT_PULSE),
    .left    (pin_left),
    .active  (pin_active)
  );

  // start-up delay chosen by fuses and clock source
  wire [18:0] su_cycles = SUT_CYCLES[{sut_fuse, xtal_select}];

  pmr_startup_timer u_sut (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (su_start),
    .cycles  (su_cycles),
    .busy    (su_busy),
    .done    (su_done)
  );

  // ==================================================================
  // power state machine
  always_comb begin
    next_state = state;
    su_start   = 1'b0;
    wake2      = 1'b0;
    case (state)
      PMR_ST_RUN: begin
        if (pwr_ctl[PMR_PC_DEEP]) begin
          next_state = PMR_ST_DOWN;
        end else if (pwr_ctl[PMR_PC_LIGHT]) begin
          next_state = PMR_ST_IDLE;
        end
      end
      PMR_ST_IDLE: begin
        if (irq_pending) begin
          next_state = PMR_ST_RUN;
        end
      end
      PMR_ST_DOWN: begin
        if (rst_active) begin
          next_state = PMR_ST_WAKE_RST;
          su_start   = 1'b1;
        end else if (|wake_ok) begin
          if (pwr_ctl[PMR_PC_WTS]) begin
            next_state = PMR_ST_WAKE_INT;
            su_start   = 1'b1;
          end else begin
            next_state = PMR_ST_WAKE_EXT;
          end
        end
      end
      PMR_ST_WAKE_INT: begin
        if (su_done) begin
          next_state = PMR_ST_RUN;
        end
      end
      PMR_ST_WAKE_EXT: begin
        if (|(irq_rise & wake_src)) begin
          next_state = PMR_ST_RUN;
        end
      end
      PMR_ST_WAKE_RST: begin
        if (su_done) begin
          next_state = PMR_ST_RUN;
          wake2      = ~rst_active;
        end
      end
      default: begin
        next_state = PMR_ST_RUN;
      end
    endcase
    if (sys_reset && !in_down) begin
      next_state = PMR_ST_RUN;
    end
  end

  wire leave_idle = state == PMR_ST_IDLE && next_state == PMR_ST_RUN;
  wire leave_wake = (state == PMR_ST_WAKE_INT || state == PMR_ST_WAKE_EXT
                     || state == PMR_ST_WAKE_RST) && next_state == PMR_ST_RUN;

  // ==================================================================
  // power_control: mode bits cleared on wake and on warm reset
  always_comb begin
    next_pwr_ctl = wr_pc ? pwdata[5:0] : pwr_ctl;
    if (leave_idle) begin
      next_pwr_ctl[PMR_PC_LIGHT] = 1'b0;
    end
    if (leave_wake) begin
      next_pwr_ctl[PMR_PC_DEEP] = 1'b0;
    end
    if (sys_reset) begin
      next_pwr_ctl = pwr_ctl & PMR_PC_RESET;
    end
  end

  // dog_config_register: hardware set wins over software clear
  always_comb begin
    next_cfg = wr_cfg ? pwdata[3:0] : cfg;
    next_cfg[PMR_CF_SOFT] = next_cfg[PMR_CF_SOFT] | soft_any;
    next_cfg[PMR_CF_OVF]  = next_cfg[PMR_CF_OVF] | key_bad;
  end

  // ==================================================================
  // register and state update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= PMR_ST_RUN;
      key_st   <= PMR_K_IDLE;
      pwr_ctl  <= PMR_PC_RESET;
      cfg      <= PMR_CF_RESET;
      irq_cfg  <= PMR_IQ_RESET;
      irq_prev <= 2'b11;
      wake_src <= 2'b00;
    end else begin
      state    <= next_state;
      key_st   <= next_key;
      pwr_ctl  <= next_pwr_ctl;
      cfg      <= next_cfg;
      irq_cfg  <= wr_irq ? pwdata[3:0] : irq_cfg;
      irq_prev <= ext_irq_n;
      wake_src <= (state == PMR_ST_DOWN) ? wake_ok : wake_src;
    end
  end

  // ==================================================================
  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr         <= PMR_PWR_RESET;
      sys_reset   <= 1'b0;
      dog_kick    <= 1'b0;
      wake_irq    <= 2'b00;
      rst_pin_out <= 1'b0;
      rst_pin_oe  <= 1'b0;
    end else begin
      pwr.cpu_clk_en     <= next_state == PMR_ST_RUN;
      pwr.periph_clk_en  <= next_state == PMR_ST_RUN
                            || next_state == PMR_ST_IDLE;
      pwr.dog_run_en     <= next_state == PMR_ST_RUN
                            || (next_state == PMR_ST_IDLE && cfg[PMR_CF_DSE]);
      pwr.osc_enable     <= next_state != PMR_ST_DOWN;
      pwr.dip_enable     <= next_state != PMR_ST_DOWN;
      pwr.flash_power_en <= next_state != PMR_ST_DOWN;
      pwr.port_hold      <= next_state != PMR_ST_RUN;
      sys_reset   <= int_active | (rst_active & ~in_down);
      dog_kick    <= key_kick;
      wake_irq    <= leave_wake && state != PMR_ST_WAKE_RST ? wake_src : 2'b00;
      rst_pin_out <= reset_sense_select;
      rst_pin_oe  <= pin_active;
    end
  end

  // ==================================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_dog_pulse_len: assert property (
    (ca_dog_match && !soft_any && int_left == 6'h00) |=> int_left == 6'h10
    ##1 int_left == 6'h0f [*1] ##14 int_left == 6'h01 ##1 int_left == 6'h00)
    else $error("counter-array reset length wrong");
  a_dog_no_pin: assert property (
    (ca_dog_match && !soft_any && pin_left == 6'h00) |=> pin_left == 6'h00)
    else $error("counter-array reset reached the pin");
  a_soft_len: assert property (
    key_soft |=> int_left == 6'h31 ##48 int_left == 6'h01)
    else $error("software reset length wrong");
  a_soft_flag: assert property (
    key_soft |=> cfg[PMR_CF_SOFT])
    else $error("soft reset flag not set");
  a_bad_key: assert property (
    key_bad |=> cfg[PMR_CF_SOFT] && cfg[PMR_CF_OVF] && int_left == 6'h31 ##1 sys_reset)
    else $error("bad key not handled");
  a_pin_drive: assert property (
    (soft_any && !cfg[PMR_CF_ROB]) |=> pin_left == 6'h31 ##1 rst_pin_oe)
    else $error("software reset not on pin");
  a_pin_block: assert property (
    (soft_any && cfg[PMR_CF_ROB] && pin_left == 6'h00) |=> pin_left == 6'h00)
    else $error("blocked reset reached the pin");
  a_sleep_clock: assert property (
    state != PMR_ST_RUN |-> !pwr.cpu_clk_en && pwr.port_hold)
    else $error("cpu clock runs while asleep");
  a_idle_dog: assert property (
    (state == PMR_ST_IDLE && !$past(cfg[PMR_CF_DSE])) |-> !pwr.dog_run_en
    && pwr.periph_clk_en && pwr.dip_enable)
    else $error("idle dog or clocks wrong");
  a_down_off: assert property (
    state == PMR_ST_DOWN |-> !pwr.osc_enable && !pwr.dip_enable && !pwr.flash_power_en)
    else $error("power-down left blocks on");
  a_idle_exit: assert property (
    (state == PMR_ST_IDLE && irq_pending) |=> state == PMR_ST_RUN
    && !pwr_ctl[PMR_PC_LIGHT] && pwr.cpu_clk_en)
    else $error("idle exit wrong");
  a_wake_timed: assert property (
    (state == PMR_ST_WAKE_INT && !su_done) |=> !pwr.cpu_clk_en)
    else $error("cpu clock before time-out");
  a_wake_ext: assert property (
    (state == PMR_ST_WAKE_EXT && !(|(irq_rise & wake_src)) && !sys_reset)
    |=> state == PMR_ST_WAKE_EXT)
    else $error("untimed wake left early");
  a_wake_two: assert property (
    (state == PMR_ST_WAKE_RST && su_done && !rst_active && !int_active)
    |=> int_left == 6'h02 ##2 int_left == 6'h00)
    else $error("two-cycle wake reset wrong");
  a_cold_keep: assert property (
    (!wr_pc && $past(!wr_pc)) |-> $stable(pwr_ctl[PMR_PC_COLD]))
    else $error("cold-start flag changed by hardware");
endmodule

// File: src/pmr_pkg.sv
// pmr_pkg: register map, field positions, key bytes, pulse lengths,
// start-up times, states and carrier types of the power/reset sequencer.
// assumes a 25 MHz pclk and one aligned 32-bit word per register.
// Functional notes
// - counter-array watchdog match makes an internal reset of exactly 16 cycles.
// - the counter-array watchdog reset never reaches the reset pin.
// - key 5AH then A5H makes a 49-cycle reset.
// - a software reset sets the soft reset flag.
// - any key pair other than 5AH A5H and the 1EH E1H watchdog kick resets at once and sets overflow and soft flags.
// - software reset drives the reset pin unless reset-out block is set.
// - light-sleep request stops the cpu clock, keeping all cpu state.
// - ports hold their levels during light sleep.
// - peripheral clocks keep running in light sleep.
// - watchdog counts in light sleep only when its sleep enable is set.
// - the supply-dip detector stays on through light sleep.
// - an enabled interrupt or any reset ends light sleep.
// - hardware clears deep bit on power-down wake, light bit on idle wake.
// - cold-start flag set by power-up, software writable, kept by warm resets.
// - deep sleep stops oscillator, supply-dip detector and flash power.
// - power-down ends only by pin reset, power-up or a qualified interrupt.
// - an external interrupt wakes only when enabled and level-sensitive.
// - timed wake: falling edge starts oscillator and timer, cpu waits for time-out.
// - untimed wake: falling edge starts oscillator, cpu waits for the rising edge.
// - reset-pin wake runs the start-up timer; early release gives a 2-cycle reset.
// - start-up time follows two fuses and clock source, 16 to 16384 us.
// - reset pin is active high when sense select is high, else active low.
// - reset-out block suppresses reset pulses on the reset pin.
package pmr_pkg;
  localparam int PMR_CLK_MHZ = 25;
  // register indices; byte address is four times the index
  localparam logic [7:0] PMR_IDX_PWRCTL = 8'h87;
  localparam logic [7:0] PMR_IDX_KEY    = 8'ha6;
  localparam logic [7:0] PMR_IDX_CFG    = 8'ha7;
  localparam logic [7:0] PMR_IDX_IRQ    = 8'ha8;
  localparam logic [7:0] PMR_IDX_STAT   = 8'ha9;
  // power_control fields
  localparam int PMR_PC_LIGHT = 0;
  localparam int PMR_PC_DEEP  = 1;
  localparam int PMR_PC_COLD  = 4;
  localparam int PMR_PC_WTS   = 5;
  localparam logic [5:0] PMR_PC_RESET = 6'h10;
  // dog_config_register fields
  localparam int PMR_CF_DSE  = 0;
  localparam int PMR_CF_ROB  = 1;
  localparam int PMR_CF_SOFT = 2;
  localparam int PMR_CF_OVF  = 3;
  localparam logic [3:0] PMR_CF_RESET = 4'h0;
  // irq_enable_reg: [1:0] enables, [3:2] edge selects
  localparam logic [3:0] PMR_IQ_RESET = 4'h0;
  // key bytes
  localparam logic [7:0] PMR_KEY_SOFT1 = 8'h5a;
  localparam logic [7:0] PMR_KEY_SOFT2 = 8'ha5;
  localparam logic [7:0] PMR_KEY_DOG1  = 8'h1e;
  localparam logic [7:0] PMR_KEY_DOG2  = 8'he1;
  // internal reset pulse lengths in cycles
  localparam logic [5:0] PMR_CA_PULSE   = 6'h10;
  localparam logic [5:0] PMR_SOFT_PULSE = 6'h31;
  localparam logic [5:0] PMR_WAKE_PULSE = 6'h02;
  // start-up times in us, index {fuse1, fuse0, crystal}
  localparam int PMR_SUT_US [8] = '{16, 1024, 512, 2048, 1024, 4096, 4096, 16384};
  function automatic logic [7:0][18:0] pmr_sut_cycles();
    logic [7:0][18:0] c;
    for (int i = 0; i < 8; i++) begin
      c[i] = 19'(PMR_SUT_US[i] * PMR_CLK_MHZ);
    end
    return c;
  endfunction
  localparam logic [7:0][18:0] PMR_SUT_CYC = pmr_sut_cycles();
  typedef enum logic [2:0] {
    PMR_ST_RUN      = 3'b000,
    PMR_ST_IDLE     = 3'b001,
    PMR_ST_DOWN     = 3'b010,
    PMR_ST_WAKE_INT = 3'b011,
    PMR_ST_WAKE_EXT = 3'b100,
    PMR_ST_WAKE_RST = 3'b101
  } pmr_state_t;
  typedef enum logic [1:0] {
    PMR_K_IDLE = 2'b00,
    PMR_K_SOFT = 2'b01,
    PMR_K_DOG  = 2'b10
  } pmr_key_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic dog_run_en;
    logic osc_enable;
    logic dip_enable;
    logic flash_power_en;
    logic port_hold;
  } pmr_pwr_t;
  localparam pmr_pwr_t PMR_PWR_RESET = 7'h7e;
endpackage

// File: src/pmr_pulse_stretch.sv
// pmr_pulse_stretch: down-counter that stretches load requests into pulses.
// assumes one clock; a longer request extends a running pulse.
`timescale 1ns/1ps
module pmr_pulse_stretch
  import pmr_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request
  input  wire logic       load,
  input  wire logic [5:0] len,
  // state
  output logic      [5:0] left,
  output logic            active
);
  logic [5:0] dec;
  logic [5:0] next_left;

  // keep whichever of remaining and requested length is longer
  assign dec       = (left != 6'h00) ? left - 6'h01 : 6'h00;
  assign next_left = (load && len > dec) ? len : dec;
  assign active    = (left != 6'h00);

  // counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 6'h00;
    end else begin
      left <= next_left;
    end
  end
endmodule

// File: src/pmr_startup_timer.sv
// pmr_startup_timer: oscillator start-up delay after a wake request.
// assumes the cycle count is nonzero; done is a one-cycle pulse.
`timescale 1ns/1ps
module pmr_startup_timer
  import pmr_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        start,
  input  wire logic [18:0] cycles,
  // status
  output logic             busy,
  output logic             done
);
  logic [18:0] cnt;

  assign busy = (cnt != 19'h0_0000);

  // count down, flag the last step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 19'h0_0000;
      done <= 1'b0;
    end else begin
      cnt  <= start ? cycles : (busy ? cnt - 19'h0_0001 : cnt);
      done <= busy && !start && cnt == 19'h0_0001;
    end
  end
endmodule

// File: testbench/pmr_far_side.sv
// pmr_far_side: reset pin and external interrupt pins beyond the sequencer.
// assumes the bench raises its requests just after a rising pclk edge.
`timescale 1ns/1ps
module pmr_far_side (
  // requests from the bench
  input  wire logic       hold_rst,
  input  wire logic [1:0] irq_low,
  input  wire logic       reset_sense_select,
  // device drive of the reset pin
  input  wire logic       rst_pin_out,
  input  wire logic       rst_pin_oe,
  // pin levels
  output logic            rst_pin_in,
  output logic [1:0]      ext_irq_n
);
  // ==========================================
  // pin levels
  // the pull resistor gives the inactive level when nobody drives
  assign rst_pin_in = rst_pin_oe ? rst_pin_out
                    : (hold_rst ? reset_sense_select : ~reset_sense_select);
  // pulled-up lines, held low as long as the source asks
  assign ext_irq_n = ~irq_low;
endmodule

// File: testbench/power_mode_reset_ctrl_tb.sv
// power_mode_reset_ctrl_tb: self-checking bench of the power/reset sequencer.
// assumes pmr_pkg and the far-side model; apb master drives at rising edges.
`timescale 1ns/1ps
module power_mode_reset_ctrl_tb;
  import pmr_pkg::*;
  localparam logic [7:0][18:0] SUT = {19'd27, 19'd26, 19'd25, 19'd24,
                                      19'd23, 19'd22, 19'd21, 19'd20};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        ca_dog_match = 0, irq_pending = 0, hold_rst = 0, rst_sense = 1, er;
  logic        pready, pslverr, rst_pin_in, rst_pin_out, rst_pin_oe, sys_reset, dog_kick;
  logic [1:0]  irq_low = '0, ext_irq_n, wake_irq, last_wake = '0;
  logic [2:0]  sut_sel = 3'b011;
  pmr_pwr_t    pwr;
  int          n_fail = 0, compares = 0, cyc = 0, oe_cnt = 0, kicks = 0, c, n0, k;

  // ==========================================
  // clock, design and far side
  always #20 pclk = ~pclk;
  pmr_power_reset_ctrl #(.SUT_CYCLES(SUT)) pmr_power_reset_ctrl_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ca_dog_match, .irq_pending, .rst_pin_in, .reset_sense_select(rst_sense),
    .rst_pin_out, .rst_pin_oe, .ext_irq_n, .sut_fuse(sut_sel[2:1]), .xtal_select(sut_sel[0]),
    .pwr, .sys_reset, .dog_kick, .wake_irq);
  pmr_far_side pmr_far_side_i (.hold_rst, .irq_low, .reset_sense_select(rst_sense),
    .rst_pin_out, .rst_pin_oe, .rst_pin_in, .ext_irq_n);

  // event counters and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rst_pin_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if (dog_kick === 1'b1) kicks <= kicks + 1;
    if (wake_irq !== 2'b00) last_wake <= wake_irq;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ==========================================
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // waits for the internal reset, then counts its cycles
  task count_rst();
    c = 0;
    for (k = 0; k < 200 && sys_reset !== 1'b1; k++) @(posedge pclk);
    while (sys_reset === 1'b1 && c < 300) begin
      @(posedge pclk);
      c++;
    end
  endtask
  task wait_cpu();
    for (k = 0; k < 100 && pwr.cpu_clk_en !== 1'b1; k++) @(posedge pclk);
  endtask

  // ==========================================
  // scenarios
  task t_regs();
    rdchk(PMR_IDX_PWRCTL, 32'h0000_0010);
    rdchk(PMR_IDX_CFG, 32'h0000_0000);
    apb(1'b1, PMR_IDX_PWRCTL, 32'h0000_0000);
    rdchk(PMR_IDX_PWRCTL, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(er, 1'b1);
  endtask
  task t_dog();
    n0 = oe_cnt;
    ca_dog_match <= 1'b1;
    @(posedge pclk);
    ca_dog_match <= 1'b0;
    count_rst();
    chk(c, 16);
    chk(oe_cnt - n0, 0);
  endtask
  task t_soft();
    n0 = oe_cnt;
    apb(1'b1, PMR_IDX_KEY, 32'h0000_005a);
    apb(1'b1, PMR_IDX_KEY, 32'h0000_00a5);
    count_rst();
    chk(c, 49);
    repeat (3) @(posedge pclk);
    chk(oe_cnt - n0, 49);
    chk(rst_pin_out, rst_sense);
    rdchk(PMR_IDX_CFG, 32'h0000_0004);
    rdchk(PMR_IDX_PWRCTL, 32'h0000_0000);
  endtask
  task t_keys();
    apb(1'b1, PMR_IDX_KEY, 32'h0000_001e);
    apb(1'b1, PMR_IDX_KEY, 32'h0000_00e1);
    repeat (5) @(posedge pclk);
    chk({kicks[3:0], sys_reset}, 5'h02);
    apb(1'b1, PMR_IDX_CFG, 32'h0000_0002);
    n0 = oe_cnt;
    apb(1'b1, PMR_IDX_KEY, 32'h0000_005a);
    apb(1'b1, PMR_IDX_KEY, 32'h0000_00e1);
    count_rst();
    chk(c, 49);
    repeat (3) @(posedge pclk);
    chk(oe_cnt - n0, 0);
    rdchk(PMR_IDX_CFG, 32'h0000_000e);
  endtask
  task t_idle();
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, PMR_IDX_CFG, 32'(s));
      apb(1'b1, PMR_IDX_PWRCTL, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk(pwr, {1'b0, 1'b1, s[0], 4'hf});
      irq_pending <= 1'b1;
      wait_cpu();
      irq_pending <= 1'b0;
      chk(k < 4, 1'b1);
      rdchk(PMR_IDX_PWRCTL, 32'h0000_0000);
    end
  endtask
  task t_timed();
    apb(1'b1, PMR_IDX_IRQ, 32'h0000_000b);
    apb(1'b1, PMR_IDX_PWRCTL, 32'h0000_0022);
    repeat (2) @(posedge pclk);
    chk({pwr.cpu_clk_en, pwr.osc_enable, pwr.dip_enable, pwr.flash_power_en}, 0);
    irq_low <= 2'b10;
    repeat (3) @(posedge pclk);
    irq_low <= 2'b00;
    repeat (30) @(posedge pclk);
    chk(pwr.cpu_clk_en, 1'b0);
    irq_low <= 2'b01;
    repeat (2) @(posedge pclk);
    irq_low <= 2'b00;
    wait_cpu();
    // fuse index 3 loads 23 cycles: done after 23, run one later, seen one later
    chk(k, 24);
    repeat (2) @(posedge pclk);
    chk(last_wake, 2'b01);
    rdchk(PMR_IDX_PWRCTL, 32'h0000_0020);
  endtask
  task t_untimed();
    apb(1'b1, PMR_IDX_PWRCTL, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    irq_low <= 2'b01;
    repeat (40) @(posedge pclk);
    chk(pwr.cpu_clk_en, 1'b0);
    irq_low <= 2'b00;
    wait_cpu();
    chk(k < 5, 1'b1);
    rdchk(PMR_IDX_PWRCTL, 32'h0000_0000);
  endtask
  // pass 0: high-active pin, 23-cycle start-up; pass 1: low-active pin, 24 cycles
  task t_pinwake();
    for (int p = 0; p < 2; p++) begin
      rst_sense <= (p == 0);
      sut_sel <= (p == 0) ? 3'b011 : 3'b100;
      apb(1'b1, PMR_IDX_PWRCTL, 32'h0000_0022);
      repeat (2) @(posedge pclk);
      hold_rst <= 1'b1;
      repeat (3) @(posedge pclk);
      hold_rst <= 1'b0;
      repeat (10) @(posedge pclk);
      count_rst();
      chk(k, 14 + p);
      chk(c, 2);
      repeat (3) @(posedge pclk);
      rdchk(PMR_IDX_PWRCTL, 32'h0000_0000);
    end
  endtask

  // ==========================================
  // verdict and main sequence
  task report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_dog();
    t_soft();
    t_keys();
    t_idle();
    t_timed();
    t_untimed();
    t_pinwake();
    report_and_stop();
  end
endmodule
